// ---- common/hmr_consts.svh ----
// Purpose: constants of the multidrop responder
// Assumes: 50 MHz clock
// Notes:   offsets are byte addresses of 32-bit words
`ifndef HMR_CONSTS_SVH
`define HMR_CONSTS_SVH
`define HMR_CLK_KHZ        50000
`define HMR_REPLY_DELAY_MS 200
`define HMR_BAUD           9600
`define HMR_A_CTRL         8'h00
`define HMR_A_IDENT        8'h04
`define HMR_A_CONC         8'h08
`define HMR_A_MAP0         8'h0c
`define HMR_A_MAP1         8'h10
`define HMR_A_MAP2         8'h14
`define HMR_A_MAP3         8'h18
`define HMR_A_STAT         8'h1c
`define HMR_CTRL_RST       32'h00000000
`define HMR_INST_ID_RST    12'h360
`define HMR_GAS_ID_RST     12'h310
`define HMR_MAP0_RST       32'h14121110
`define HMR_MAP1_RST       32'h19181615
`define HMR_MAP2_RST       32'h00001b1a
`define HMR_MAP3_RST       32'h00000000
`define HMR_UNIT_POS       13
`define HMR_COND_ZERO      8
`define HMR_COND_SPAN      9
`define HMR_DATA_BITS      7
`define HMR_FRAME_BITS     11
`define HMR_CH_STX         8'h02
`define HMR_CH_ETX         8'h03
`define HMR_CH_CR          8'h0d
`define HMR_CH_SP          8'h20
`define HMR_CH_ZERO_CMD    8'h5a
`define HMR_CH_SPAN_CMD    8'h50
`define HMR_CH_MEAS_CMD    8'h4d
`define HMR_CH_STAT_CMD    8'h53
`endif

// ---- common/hmr_pkg.sv ----
// Purpose: types of the multidrop responder
// Assumes: nothing
// Notes:   constants live in hmr_consts.svh
package hmr_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_SEND = 3'b100
  } hmr_state_e;
  typedef enum logic [1:0] {
    CAL_MEASURE = 2'h0,
    CAL_ZERO    = 2'h1,
    CAL_SPAN    = 2'h2
  } hmr_cal_e;
  typedef enum logic [1:0] {
    RESP_CMD  = 2'h0,
    RESP_CHK  = 2'h1,
    RESP_TEXT = 2'h2
  } hmr_resp_e;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } hmr_req_s;
endpackage

// ---- core/hmr_responder.sv ----
// Purpose: multidrop polled responder, two serial ports, register port
// Assumes: host keeps line settings matched and polls slowly
// Notes:   replies go out on the port the command came in on
// Operation
// R1 - never talk unless addressed by own id
// R2 - seven data bits, even parity, two stops
// R3 - host matches character format and line settings
// R4 - wait about 200 ms before replying
// R5 - host polls one instrument slowly
// R6 - protocol enabled per serial port
// R7 - one protocol version setting for both ports
// R8 - echo mode framing follows command encoding
// R9 - checksum mode: stx, etx, two-digit check
// R10 - text mode: carriage return both ends
// R11 - gas identifier defaults to 310
// R12 - status word with configurable condition bits
// R13 - shared status bit is or of conditions
// R14 - default warning bit assignments
// R15 - default operational bit assignments
// R16 - unit code in status word
// R17 - other conditions unassigned by default
// R18 - instrument id defaults to 360, matched
// R19 - status reply; zero, span, measure commands
// R20 - check code xor, two hex digits
`include "hmr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module hmr_responder #(
  parameter int unsigned REPLY_DELAY_CYC = `HMR_REPLY_DELAY_MS * `HMR_CLK_KHZ,
  parameter int unsigned BIT_CYC         = `HMR_CLK_KHZ * 1000 / `HMR_BAUD
)(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // register port
  input  wire hmr_pkg::hmr_req_s req,
  output logic [31:0]           rdata_q,
  // serial ports
  input  wire logic [1:0]       rx,
  output logic [1:0]            tx_q,
  output logic [1:0]            tx_oe_q,
  // instrument conditions and mode
  input  wire logic [15:0]      cond_in,
  output hmr_pkg::hmr_cal_e     cal_q
);
  logic [31:0] ctrl_q;
  logic [11:0] inst_id_q;
  logic [11:0] gas_id_q;
  logic [17:0] conc_q;
  logic [31:0] map_q [4];
  logic [15:0] status_w;
  hmr_pkg::hmr_state_e st_q;
  // ctrl: [1:0] port enables, [2] version, [4:3] response mode
  wire [1:0] port_en = ctrl_q[1:0];
  wire       ver2    = ctrl_q[2];
  wire [1:0] rmode   = ctrl_q[4:3];

  // register writes
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ctrl_q    <= `HMR_CTRL_RST;
      inst_id_q <= `HMR_INST_ID_RST; // R18
      gas_id_q  <= `HMR_GAS_ID_RST; // R11
      conc_q    <= 18'h00000;
      map_q[0]  <= `HMR_MAP0_RST; // R14
      map_q[1]  <= `HMR_MAP1_RST; // R14 R15
      map_q[2]  <= `HMR_MAP2_RST; // R15
      map_q[3]  <= `HMR_MAP3_RST; // R17
    end
    else if (req.wr)
    begin
      case (req.addr)
        `HMR_A_CTRL:  ctrl_q <= {27'h0000000, req.wdata[4:0]}; // R6 R7
        `HMR_A_IDENT:
        begin
          inst_id_q <= req.wdata[11:0];
          gas_id_q  <= req.wdata[27:16];
        end
        `HMR_A_CONC:  conc_q <= req.wdata[17:0];
        `HMR_A_MAP0:  map_q[0] <= req.wdata;
        `HMR_A_MAP1:  map_q[1] <= req.wdata;
        `HMR_A_MAP2:  map_q[2] <= req.wdata;
        `HMR_A_MAP3:  map_q[3] <= req.wdata;
        default:      ;
      endcase
    end
  end

  // register reads, data only in the following cycle
  always_ff @(posedge clock)
  begin
    if (!rstn || !req.rd)
      rdata_q <= 32'h00000000;
    else
    begin
      case (req.addr)
        `HMR_A_CTRL:  rdata_q <= ctrl_q;
        `HMR_A_IDENT: rdata_q <= {4'h0, gas_id_q, 4'h0, inst_id_q};
        `HMR_A_CONC:  rdata_q <= {14'h0000, conc_q};
        `HMR_A_MAP0:  rdata_q <= map_q[0];
        `HMR_A_MAP1:  rdata_q <= map_q[1];
        `HMR_A_MAP2:  rdata_q <= map_q[2];
        `HMR_A_MAP3:  rdata_q <= map_q[3];
        `HMR_A_STAT:  rdata_q <= {11'h000, st_q, cal_q, status_w};
        default:      rdata_q <= 32'h00000000;
      endcase
    end
  end

  // status word from mapped conditions
  logic [15:0] cond_w;
  logic [15:0] contrib [16];
  always_comb
  begin
    cond_w = cond_in;
    cond_w[`HMR_COND_ZERO] = cond_in[`HMR_COND_ZERO] | (cal_q == hmr_pkg::CAL_ZERO);
    cond_w[`HMR_COND_SPAN] = cond_in[`HMR_COND_SPAN] | (cal_q == hmr_pkg::CAL_SPAN);
  end
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_map
      wire [7:0] fld = map_q[gi/4][8*(gi%4) +: 8];
      assign contrib[gi] = (cond_w[gi] && fld[4]) ? (16'h0001 << fld[3:0]) : 16'h0000; // R12
    end
  endgenerate
  always_comb
  begin
    status_w = 16'h0000;
    for (int i = 0; i < 16; i++)
      status_w = status_w | contrib[i]; // R13
    status_w[`HMR_UNIT_POS +: 2] = status_w[`HMR_UNIT_POS +: 2] | conc_q[17:16]; // R16
  end

  // pin synchronisers, change taken when stages two and three agree
  logic [1:0] s1_q, s2_q, s3_q, rxf_q;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (!rstn)
        begin
          s1_q[gi]  <= 1'b1;
          s2_q[gi]  <= 1'b1;
          s3_q[gi]  <= 1'b1;
          rxf_q[gi] <= 1'b1;
        end
        else
        begin
          s1_q[gi] <= rx[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            rxf_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate
  wire [1:0] rx_live = rxf_q | ~port_en; // R6
  wire       rx_line = &rx_live;

  // receiver: start, 7 data, even parity, 2 stops
  logic        rx_run_q, rx_ok_q, rx_vld_q, src_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rx_run_q <= 1'b0;
      rx_ok_q  <= 1'b0;
      rx_vld_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 8'h00;
      src_q    <= 1'b0;
    end
    else
    begin
      rx_vld_q <= 1'b0;
      if (!rx_run_q)
      begin
        if (!rx_line && st_q == hmr_pkg::S_IDLE)
        begin
          rx_run_q <= 1'b1;
          rx_ok_q  <= 1'b1;
          rx_bit_q <= 4'h0;
          rx_cnt_q <= 16'(BIT_CYC / 2);
          src_q    <= rx_live[0];
        end
      end
      else if (rx_cnt_q != 16'h0000)
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      else
      begin
        rx_cnt_q <= 16'(BIT_CYC - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_line)
          rx_run_q <= 1'b0;
        else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8)
          rx_sh_q <= {rx_line, rx_sh_q[7:1]};
        else if (rx_bit_q >= 4'h9)
        begin
          if (!rx_line)
            rx_ok_q <= 1'b0; // R2
          if (rx_bit_q == 4'(`HMR_FRAME_BITS - 1))
          begin
            rx_run_q <= 1'b0;
            rx_vld_q <= rx_ok_q && rx_line && !(^rx_sh_q); // R2
          end
        end
      end
    end
  end
  wire [7:0] rx_ch = {1'b0, rx_sh_q[6:0]};

  // command parser: [stx] letter id-digits cr|etx
  logic       p_stx_q, p_have_q, p_match_q;
  logic [7:0] p_cmd_q;
  logic [1:0] p_cnt_q;
  wire is_term = rx_ch == `HMR_CH_CR || rx_ch == `HMR_CH_ETX;
  wire is_cmd  = rx_ch == `HMR_CH_ZERO_CMD || rx_ch == `HMR_CH_SPAN_CMD ||
                 rx_ch == `HMR_CH_MEAS_CMD || rx_ch == `HMR_CH_STAT_CMD;
  wire is_dig  = rx_ch[7:4] == 4'h3 && rx_ch[3:0] <= 4'h9;
  wire [3:0] id_dig = (p_cnt_q == 2'h0) ? inst_id_q[11:8] :
                      (p_cnt_q == 2'h1) ? inst_id_q[7:4] : inst_id_q[3:0];
  wire accept = rx_vld_q && st_q == hmr_pkg::S_IDLE && is_term &&
                p_have_q && p_match_q && p_cnt_q == 2'h3; // R1 R18
  always_ff @(posedge clock)
  begin
    if (!rstn || (rx_vld_q && (rx_ch == `HMR_CH_STX || is_term)))
    begin
      p_stx_q   <= rstn && rx_ch == `HMR_CH_STX;
      p_have_q  <= 1'b0;
      p_match_q <= 1'b1;
      p_cnt_q   <= 2'h0;
      p_cmd_q   <= 8'h00;
    end
    else if (rx_vld_q)
    begin
      if (!p_have_q)
      begin
        p_have_q <= is_cmd;
        p_cmd_q  <= rx_ch;
      end
      else if (is_dig && p_cnt_q != 2'h3)
      begin
        p_match_q <= p_match_q && rx_ch[3:0] == id_dig; // R18
        p_cnt_q   <= p_cnt_q + 2'h1;
      end
      else
        p_match_q <= 1'b0; // R1
    end
  end

  // calibration mode from host commands
  always_ff @(posedge clock)
  begin
    if (!rstn)
      cal_q <= hmr_pkg::CAL_MEASURE;
    else if (accept)
    begin
      case (p_cmd_q)
        `HMR_CH_ZERO_CMD: cal_q <= hmr_pkg::CAL_ZERO; // R19
        `HMR_CH_SPAN_CMD: cal_q <= hmr_pkg::CAL_SPAN; // R19
        `HMR_CH_MEAS_CMD: cal_q <= hmr_pkg::CAL_MEASURE; // R19
        default:          ;
      endcase
    end
  end

  // reply sequencing
  function automatic [7:0] hex(input [3:0] n);
    hex = (n <= 4'h9) ? {4'h3, n} : (8'h37 + {4'h0, n});
  endfunction
  logic [23:0] dly_q;
  logic [4:0]  pos_q;
  logic [7:0]  bcc_q, echo_q;
  logic [15:0] snap_st_q, snap_conc_q;
  logic        chk_q, v2_q, tx_busy_q;
  logic [10:0] tx_sh_q;
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [7:0]  ch_w;
  wire [4:0] last_pos = chk_q ? 5'd22 : 5'd20;
  wire [4:0] next_pos = (!v2_q && pos_q == 5'd5) ? 5'd10 : pos_q + 5'd1; // R7
  always_comb
  begin
    case (pos_q)
      5'd0:    ch_w = chk_q ? `HMR_CH_STX : `HMR_CH_CR; // R8 R9 R10
      5'd1:    ch_w = echo_q;
      5'd2:    ch_w = hex(inst_id_q[11:8]);
      5'd3:    ch_w = hex(inst_id_q[7:4]);
      5'd4:    ch_w = hex(inst_id_q[3:0]);
      5'd6:    ch_w = hex(gas_id_q[11:8]); // R11
      5'd7:    ch_w = hex(gas_id_q[7:4]);
      5'd8:    ch_w = hex(gas_id_q[3:0]);
      5'd10:   ch_w = hex(snap_conc_q[15:12]); // R19
      5'd11:   ch_w = hex(snap_conc_q[11:8]);
      5'd12:   ch_w = hex(snap_conc_q[7:4]);
      5'd13:   ch_w = hex(snap_conc_q[3:0]);
      5'd15:   ch_w = hex(snap_st_q[15:12]); // R12
      5'd16:   ch_w = hex(snap_st_q[11:8]);
      5'd17:   ch_w = hex(snap_st_q[7:4]);
      5'd18:   ch_w = hex(snap_st_q[3:0]);
      5'd19:   ch_w = chk_q ? `HMR_CH_ETX : `HMR_CH_CR; // R9 R10
      5'd20:   ch_w = hex(bcc_q[7:4]); // R20
      5'd21:   ch_w = hex(bcc_q[3:0]); // R20
      default: ch_w = `HMR_CH_SP;
    endcase
  end
  wire load = st_q == hmr_pkg::S_SEND && !tx_busy_q && pos_q != last_pos;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_q        <= hmr_pkg::S_IDLE;
      dly_q       <= 24'h000000;
      pos_q       <= 5'd0;
      bcc_q       <= 8'h00;
      echo_q      <= 8'h00;
      chk_q       <= 1'b0;
      v2_q        <= 1'b0;
      snap_st_q   <= 16'h0000;
      snap_conc_q <= 16'h0000;
    end
    else
    begin
      case (st_q)
        hmr_pkg::S_IDLE:
          if (accept)
          begin
            st_q        <= hmr_pkg::S_WAIT;
            dly_q       <= 24'h000000;
            pos_q       <= 5'd0;
            bcc_q       <= 8'h00;
            echo_q      <= p_cmd_q;
            v2_q        <= ver2;
            chk_q       <= rmode == hmr_pkg::RESP_CHK ||
                           (rmode != hmr_pkg::RESP_TEXT && p_stx_q); // R8 R9 R10
          end
        hmr_pkg::S_WAIT:
        begin
          dly_q <= dly_q + 24'h000001;
          if (dly_q == 24'(REPLY_DELAY_CYC - 1))
          begin
            st_q        <= hmr_pkg::S_SEND; // R4
            snap_st_q   <= status_w;
            snap_conc_q <= conc_q[15:0];
          end
        end
        hmr_pkg::S_SEND:
          if (load)
          begin
            pos_q <= next_pos;
            if (pos_q != 5'd0 && pos_q <= 5'd19)
              bcc_q <= bcc_q ^ ch_w; // R20
          end
          else if (!tx_busy_q && pos_q == last_pos)
            st_q <= hmr_pkg::S_IDLE;
        default: st_q <= hmr_pkg::S_IDLE;
      endcase
    end
  end

  // transmitter, driven only on the port that was addressed
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 11'h7ff;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_q      <= 2'h3;
      tx_oe_q   <= 2'h0;
    end
    else
    begin
      if (load)
      begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {2'h3, ^ch_w[6:0], ch_w[6:0], 1'b0}; // R2
        tx_cnt_q  <= 16'(BIT_CYC - 1);
        tx_bit_q  <= 4'h0;
      end
      else if (tx_busy_q)
      begin
        if (tx_cnt_q != 16'h0000)
          tx_cnt_q <= tx_cnt_q - 16'h0001;
        else
        begin
          tx_cnt_q <= 16'(BIT_CYC - 1);
          tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == 4'(`HMR_FRAME_BITS - 1))
            tx_busy_q <= 1'b0;
        end
      end
      tx_q[0]    <= !(tx_busy_q && !src_q) || tx_sh_q[0];
      tx_q[1]    <= !(tx_busy_q && src_q) || tx_sh_q[0];
      tx_oe_q[0] <= st_q == hmr_pkg::S_SEND && !src_q && port_en[0]; // R1 R6
      tx_oe_q[1] <= st_q == hmr_pkg::S_SEND && src_q && port_en[1]; // R1 R6
    end
  end

  // checks
  property p_quiet;
    @(posedge clock) disable iff (!rstn)
      $past(st_q) != hmr_pkg::S_SEND |-> tx_oe_q == 2'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("drive while not replying"); // R1
  property p_delay;
    @(posedge clock) disable iff (!rstn)
      st_q == hmr_pkg::S_SEND && $past(st_q) == hmr_pkg::S_WAIT
      |-> $past(dly_q) == 24'(REPLY_DELAY_CYC - 1);
  endproperty
  a_delay: assert property (p_delay) else $error("reply delay wrong"); // R4
  property p_stop;
    @(posedge clock) disable iff (!rstn)
      tx_busy_q && tx_bit_q >= 4'h9 |-> tx_sh_q[0];
  endproperty
  a_stop: assert property (p_stop) else $error("stop bit low"); // R2
  property p_enable;
    @(posedge clock) disable iff (!rstn)
      tx_oe_q[1] |-> $past(port_en[1]);
  endproperty
  a_enable: assert property (p_enable) else $error("disabled port driven"); // R6
  property p_chk_frame;
    @(posedge clock) disable iff (!rstn)
      load && chk_q && pos_q == 5'd19 |-> ch_w == `HMR_CH_ETX ##1 pos_q == 5'd20;
  endproperty
  a_chk_frame: assert property (p_chk_frame) else $error("etx missing"); // R9
  property p_text_frame;
    @(posedge clock) disable iff (!rstn)
      load && !chk_q && pos_q == 5'd0 |-> ch_w == `HMR_CH_CR;
  endproperty
  a_text_frame: assert property (p_text_frame) else $error("leading cr missing"); // R10
  property p_units;
    @(posedge clock) disable iff (!rstn)
      (status_w[14:13] & conc_q[17:16]) == conc_q[17:16];
  endproperty
  a_units: assert property (p_units) else $error("unit code lost"); // R16
  property p_or;
    @(posedge clock) disable iff (!rstn)
      cond_w[0] && map_q[0][4] |-> status_w[map_q[0][3:0]];
  endproperty
  a_or: assert property (p_or) else $error("mapped condition not shown"); // R13
  property p_zero;
    @(posedge clock) disable iff (!rstn)
      accept && p_cmd_q == `HMR_CH_ZERO_CMD |=> cal_q == hmr_pkg::CAL_ZERO ##1
      st_q == hmr_pkg::S_WAIT;
  endproperty
  a_zero: assert property (p_zero) else $error("zero command not taken"); // R19
  property p_addr;
    @(posedge clock) disable iff (!rstn)
      $rose(st_q == hmr_pkg::S_WAIT) |-> $past(p_match_q) && $past(p_cnt_q) == 2'h3;
  endproperty
  a_addr: assert property (p_addr) else $error("reply without own id"); // R1 R18
endmodule
`default_nettype wire

// ---- tb/hmr_host.sv ----
// Purpose: host model polling the responder on two serial lines
// Assumes: called just after a rising edge
// Notes:   a released line rests at mark
`timescale 1ns/10ps
`default_nettype none
module hmr_host #(
  parameter int unsigned BIT_CYC = 8
)(
  // clock
  input  wire logic       clock,
  // toward responder
  output logic [1:0]      line_out,
  // from responder
  input  wire logic [1:0] line_in,
  input  wire logic [1:0] oe_in
);
  logic [1:0] lvl;
  initial line_out = 2'b11;
  assign lvl = (oe_in & line_in) | ~oe_in;

  // send one character, host format matched to device
  task automatic send_char(input int p, input logic [7:0] c);
    logic [10:0] f;
    f = {2'b11, ^c[6:0], c[6:0], 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_out[p] <= f[i];
      repeat (BIT_CYC) @(posedge clock);
    end
  endtask

  // receive one character, sampled mid bit
  task automatic recv_char(input int p, output logic [7:0] c, output logic ok);
    logic [10:0] f;
    int          n;
    n = 0;
    @(negedge clock);
    while (lvl[p] !== 1'b0 && n < 4000)
    begin
      @(negedge clock);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge clock);
    f[0] = lvl[p];
    for (int i = 1; i < 11; i++)
    begin
      repeat (BIT_CYC) @(negedge clock);
      f[i] = lvl[p];
    end
    c = {1'b0, f[7:1]};
    ok = (f[0] === 1'b0) && (f[10:9] === 2'b11) && ((^f[8:1]) === 1'b0);
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ---- tb/hmr_responder_tb_top.sv ----
// Purpose: self-checking bench of the multidrop responder
// Assumes: short reply delay and bit time
// Notes:   host polls again only after each reply or after a 300-cycle silent watch
`timescale 1ns/10ps
`default_nettype none
`include "hmr_consts.svh"
module hmr_responder_tb_top;
  localparam logic [15:0] ST [16] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010,
    16'h0020, 16'h0040, 16'h0100, 16'h0200, 16'h0400, 16'h0800,
    16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic              clock = 1'b0;
  logic              rstn = 1'b0;
  hmr_pkg::hmr_req_s req = '0;
  logic [1:0]        rx;
  logic [31:0]       rdata_q;
  logic [1:0]        tx_q;
  logic [1:0]        tx_oe_q;
  logic [15:0]       cond_in = 16'h0000;
  hmr_pkg::hmr_cal_e cal_q;
  logic [31:0]       rd;
  int                fail_count = 0;
  int                samples_checked = 0;

  always #10 clock = ~clock;

  hmr_responder #(.REPLY_DELAY_CYC(50), .BIT_CYC(8)) dut_u (
    .clock(clock), .rstn(rstn), .req(req), .rdata_q(rdata_q), .rx(rx),
    .tx_q(tx_q), .tx_oe_q(tx_oe_q), .cond_in(cond_in), .cal_q(cal_q));

  hmr_host #(.BIT_CYC(8)) host_u (
    .clock(clock), .line_out(rx), .line_in(tx_q), .oe_in(tx_oe_q));

  task automatic results();
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    d = rdata_q;
    @(posedge clock);
  endtask

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction

  function automatic string bcc(input string s);
    logic [7:0] x;
    string      r;
    x = 8'h00;
    for (int i = 1; i < s.len(); i++)
      x = x ^ s[i];
    r = {s, "00"};
    r.putc(r.len() - 2, hx(x[7:4]));
    r.putc(r.len() - 1, hx(x[3:0]));
    return r;
  endfunction

  // command, then reply timing, framing and line release
  task automatic run(input int p, input string s, input string exp);
    logic [7:0] c;
    logic       ok;
    int         n;
    for (int i = 0; i < s.len(); i++)
      host_u.send_char(p, s[i]);
    n = 0;
    while (tx_oe_q[p] !== 1'b1 && n < 500)
    begin
      @(negedge clock);
      n++;
    end
    check("reply delay", 32'h1, 32'(n >= 35 && n <= 70));
    for (int i = 0; i < exp.len(); i++)
    begin
      host_u.recv_char(p, c, ok);
      check("reply char", {23'h0, 1'b1, exp[i]}, {23'h0, ok, c});
    end
    repeat (8) @(posedge clock);
    @(negedge clock);
    check("line release", 32'h0, {30'h0, tx_oe_q});
    @(posedge clock);
  endtask

  // command that must draw no reply
  task automatic quiet(input int p, input string s);
    int n;
    n = 0;
    for (int i = 0; i < s.len(); i++)
      host_u.send_char(p, s[i]);
    repeat (300)
    begin
      @(negedge clock);
      n += (tx_oe_q !== 2'b00);
    end
    check("silent line", 32'h0, 32'(n));
    @(posedge clock);
  endtask

  initial
  begin
    repeat (40000) @(posedge clock);
    fail_count++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check("reset pins", 32'h30, {26'h0, tx_q, tx_oe_q, cal_q});
    check("reset rdata", 32'h0, rdata_q);
    @(posedge clock);
    rdr(`HMR_A_IDENT, rd);
    check("ident", 32'h03100360, rd);
    rdr(`HMR_A_CTRL, rd);
    check("ctrl", 32'h0, rd);
    rdr(8'h20, rd);
    check("unmapped", 32'h0, rd);
    quiet(0, "S360\015");
    for (int u = 0; u < 4; u++)
    begin
      wr(`HMR_A_CONC, {14'h0, 2'(u), 16'h1234});
      for (int i = 0; i < 16; i++)
      begin
        cond_in <= 16'h1 << i;
        repeat (2) @(posedge clock);
        rdr(`HMR_A_STAT, rd);
        check("status", {16'h0, ST[i] | 16'(u) << 13}, {14'h0, rd[17:0]});
      end
    end
    wr(`HMR_A_MAP0, 32'h14101110);
    for (int k = 4; k < 6; k++)
    begin
      cond_in <= 16'(k);
      repeat (2) @(posedge clock);
      rdr(`HMR_A_STAT, rd);
      check("shared bit", 32'h6001, {16'h0, rd[15:0]});
    end
    wr(`HMR_A_MAP0, `HMR_MAP0_RST);
    cond_in <= 16'h0009;
    wr(`HMR_A_CTRL, 32'h1);
    run(0, "\002S360\003", bcc("\002S360 1234 6011\003"));
    cond_in <= 16'h0000;
    quiet(0, "S361\015");
    wr(`HMR_A_CTRL, 32'h9);
    run(0, "M360\015", bcc("\002M360 1234 6000\003"));
    wr(`HMR_A_CTRL, 32'h1);
    run(0, "S360\015", "\015S360 1234 6000\015");
    wr(`HMR_A_CTRL, 32'h16);
    run(1, "\002Z360\003", "\015Z360 310 1234 6400\015");
    check("zero mode", 32'(hmr_pkg::CAL_ZERO), 32'(cal_q));
    run(1, "P360\015", "\015P360 310 1234 6800\015");
    check("span mode", 32'(hmr_pkg::CAL_SPAN), 32'(cal_q));
    run(1, "M360\015", "\015M360 310 1234 6000\015");
    check("measure mode", 32'(hmr_pkg::CAL_MEASURE), 32'(cal_q));
    quiet(0, "S360\015");
    results();
  end
endmodule
`default_nettype wire
